// ===== rtl/phy_mgmt_consts.svh
// register indices, field positions and reset values of the management bank
`ifndef PHY_MGMT_CONSTS_SVH
`define PHY_MGMT_CONSTS_SVH

`define IDX_ADVERT 5'h04
`define IDX_PARTNER_BASE 5'h05
`define IDX_EXPANSION 5'h06
`define IDX_NP_TX 5'h07
`define IDX_NP_RX 5'h08
`define IDX_GIG_CTRL 5'h09
`define IDX_GIG_STAT 5'h0A
`define IDX_MMD_CTRL 5'h0D
`define IDX_MMD_DATA 5'h0E
`define IDX_GIG_EXT1 5'h0F
`define IDX_FE_EXT 5'h10
`define IDX_GIG_EXT2 5'h11
`define IDX_LAST_FIXED 5'h0F

`define ADVERT_RESET 16'h01E1
`define ADVERT_MASK 16'hADFF
`define NP_TX_RESET 16'h2001
`define NP_TX_MASK 16'hB7FF
`define NP_TOGGLE_BIT 11
`define GIG_CTRL_RESET 16'h0300
`define GIG_CTRL_MASK 16'hFF00
`define TEST_MODE_HI 15
`define TEST_MODE_LO 13
`define TEST_MODE_MAX 3'h4
`define MS_MANUAL_BIT 12
`define MS_VALUE_BIT 11
`define PORT_TYPE_BIT 10
`define GIG_ADV_HI 9
`define GIG_ADV_LO 8
`define MMD_DEV_HI 4
`define MMD_DEV_LO 0
`define NEXT_PAGE_BIT 15
`define MMD_CTRL_MASK 16'hC01F
`define MMD_FUNC_HI 15
`define MMD_FUNC_LO 14
`define GIG_EXT1_VALUE 16'h3000
`define EXP_NP_ABLE 1'h1
`define PARTNER_BASE_MASK 16'hEFFF
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define COUNT_MAX 8'hFF

`endif

// ===== rtl/phy_mgmt_pkg.sv
// types shared by the management register bank
package phy_mgmt_pkg;
  typedef logic [15:0] word_t;
  typedef logic [4:0] index_t;
  typedef enum logic [1:0] {
    mmd_address = 2'h0,
    mmd_data_plain = 2'h1,
    mmd_data_inc_rw = 2'h2,
    mmd_data_inc_wr = 2'h3
  } mmd_func_e;
endpackage

// ===== rtl/clear_on_read_flag.sv
// sticky flag set by hardware, cleared by a read; set wins over the clear
`timescale 1ns/1ps
module clear_on_read_flag (
  input wire logic clk_in, // core clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic set_in, // event pulse or level
  input wire logic clear_in, // register read strobe
  output logic flag_out // latched flag
);
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule

// ===== rtl/phy_mgmt_regs.sv
// auto-negotiation, gigabit and mmd window management registers
`timescale 1ns/1ps
`include "phy_mgmt_consts.svh"

module phy_mgmt_regs (
  input wire logic clk_in, // core clock, 200 MHz
  input wire logic resetn_in, // synchronous reset, active low
  input wire phy_mgmt_pkg::index_t reg_index_in, // register index
  input wire logic [1:0] ext_page_in, // extended page select
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire phy_mgmt_pkg::word_t wr_data_in, // write data
  output phy_mgmt_pkg::word_t rd_data_out, // read data
  output logic rd_valid_out, // read data valid pulse
  input wire phy_mgmt_pkg::word_t partner_base_in, // received base page
  input wire logic partner_base_load_in, // base page received pulse
  input wire phy_mgmt_pkg::word_t partner_np_in, // received next page
  input wire logic partner_np_load_in, // next page received pulse
  input wire logic partner_an_able_in, // partner negotiates
  input wire logic parallel_fault_in, // parallel detect fault
  input wire logic np_sent_in, // next page transmitted pulse
  output phy_mgmt_pkg::word_t np_tx_word_out, // next page to send
  output phy_mgmt_pkg::word_t advert_out, // advertisement word
  output logic [2:0] test_mode_out, // transmitter test mode
  output logic force_role_out, // role forced manually
  output logic forced_master_out, // forced role is master
  output logic multi_port_out, // port type
  output logic [1:0] gig_advert_out, // full, half duplex advert
  input wire logic ms_fault_in, // master/slave config fault
  input wire logic role_master_in, // resolved role master
  input wire logic local_rx_ok_in, // local receiver ok
  input wire logic remote_rx_ok_in, // remote receiver ok
  input wire logic [1:0] partner_gig_in, // partner gig full, half
  input wire logic idle_error_in, // idle error pulse
  input wire logic [1:0] fe_live_in, // locked, link
  input wire logic [5:0] fe_err_in, // 14,13,11,10,9,8 events
  input wire logic [1:0] gig_live_in, // locked, link
  input wire logic [6:0] gig_err_in, // 14,13,11..7 events
  output logic [1:0] mmd_func_out, // mmd access function
  output logic [4:0] mmd_dev_out, // mmd device address
  output phy_mgmt_pkg::word_t mmd_addr_data_out, // mmd addr/data
  output logic mmd_access_out // data phase access pulse
);
  import phy_mgmt_pkg::*;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function automatic logic hit(input index_t idx, input index_t want,
                               input logic [1:0] page);
    // upper indices only live on the main page
    hit = (idx == want) &&
          ((want <= `IDX_LAST_FIXED) || (page == 2'h0));
  endfunction

  wire wr_advert = wr_in && hit(reg_index_in, `IDX_ADVERT, ext_page_in);
  wire wr_np_tx = wr_in && hit(reg_index_in, `IDX_NP_TX, ext_page_in);
  wire wr_gig_ctrl = wr_in && hit(reg_index_in, `IDX_GIG_CTRL, ext_page_in);
  wire wr_mmd_ctrl = wr_in && hit(reg_index_in, `IDX_MMD_CTRL, ext_page_in);
  wire wr_mmd_data = wr_in && hit(reg_index_in, `IDX_MMD_DATA, ext_page_in);
  wire rd_exp = rd_in && hit(reg_index_in, `IDX_EXPANSION, ext_page_in);
  wire rd_gig_stat = rd_in && hit(reg_index_in, `IDX_GIG_STAT, ext_page_in);
  wire rd_mmd_data = rd_in && hit(reg_index_in, `IDX_MMD_DATA, ext_page_in);
  wire rd_fe = rd_in && hit(reg_index_in, `IDX_FE_EXT, ext_page_in);
  wire rd_gig2 = rd_in && hit(reg_index_in, `IDX_GIG_EXT2, ext_page_in);

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  word_t advert;
  word_t np_tx;
  word_t gig_ctrl;
  word_t mmd_ctrl;
  word_t mmd_addr_data;
  word_t partner_base;
  word_t partner_np;
  logic last_toggle;
  logic [7:0] idle_count;

  wire [2:0] wr_test_mode = wr_data_in[`TEST_MODE_HI:`TEST_MODE_LO];
  // reserved test codes keep the previous mode
  wire test_ok = (wr_test_mode <= `TEST_MODE_MAX);
  wire [2:0] next_test_mode = test_ok ? wr_test_mode :
                              gig_ctrl[`TEST_MODE_HI:`TEST_MODE_LO];
  wire word_t next_gig_ctrl = {next_test_mode,
                               wr_data_in[`MS_MANUAL_BIT:0]} & `GIG_CTRL_MASK;
  wire mmd_func_e func = mmd_func_e'(mmd_ctrl[`MMD_FUNC_HI:`MMD_FUNC_LO]);
  wire data_phase = (func != mmd_address);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      advert <= `ADVERT_RESET;
      np_tx <= `NP_TX_RESET;
      gig_ctrl <= `GIG_CTRL_RESET;
      mmd_ctrl <= `ZERO16;
      mmd_addr_data <= `ZERO16;
    end else begin
      if (wr_advert) begin
        advert <= wr_data_in & `ADVERT_MASK;
      end
      if (wr_np_tx) begin
        np_tx <= wr_data_in & `NP_TX_MASK;
      end
      if (wr_gig_ctrl) begin
        gig_ctrl <= next_gig_ctrl;
      end
      if (wr_mmd_ctrl) begin
        mmd_ctrl <= wr_data_in & `MMD_CTRL_MASK;
      end
      // window holds data; increment stays outside this bank
      if (wr_mmd_data) begin
        mmd_addr_data <= wr_data_in;
      end
    end
  end

  // ----------------------------------------
  // received pages and toggle tracking
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      partner_base <= `ZERO16;
      partner_np <= `ZERO16;
      last_toggle <= 1'b1;
    end else begin
      if (partner_base_load_in) begin
        partner_base <= partner_base_in & `PARTNER_BASE_MASK;
      end
      if (partner_np_load_in) begin
        partner_np <= partner_np_in;
      end
      if (np_sent_in) begin
        last_toggle <= np_tx_word_out[`NP_TOGGLE_BIT];
      end
    end
  end

  // ----------------------------------------
  // latched and read-clear flags
  // ----------------------------------------
  wire [15:0] set_vec = {fe_err_in, gig_err_in, ms_fault_in,
                         parallel_fault_in, partner_np_load_in};
  wire [15:0] clr_vec = {{6{rd_fe}}, {7{rd_gig2}}, rd_gig_stat,
                         rd_exp, rd_exp};
  logic [15:0] flags;

  generate
    for (genvar i = 0; i < 16; i++) begin : g_flag
      clear_on_read_flag u_flag (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .set_in(set_vec[i]),
        .clear_in(clr_vec[i]),
        .flag_out(flags[i])
      );
    end
  endgenerate

  wire page_rx = flags[0];
  wire par_fault = flags[1];
  wire ms_fault = flags[2];
  wire [6:0] gig_flags = flags[9:3];
  wire [5:0] fe_flags = flags[15:10];

  // count saturates; an error on the read cycle starts the new count
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      idle_count <= `ZERO8;
    end else if (rd_gig_stat) begin
      idle_count <= idle_error_in ? 8'h01 : `ZERO8;
    end else if (idle_error_in && idle_count != `COUNT_MAX) begin
      idle_count <= idle_count + 8'h01;
    end
  end

  // ----------------------------------------
  // read views
  // ----------------------------------------
  wire partner_np_able = partner_np[`NEXT_PAGE_BIT] |
                         partner_base[`NEXT_PAGE_BIT];
  wire word_t exp_view = {11'h000, par_fault, partner_np_able,
                          `EXP_NP_ABLE, page_rx, partner_an_able_in};
  wire word_t np_tx_view = {np_tx[15:12], ~last_toggle, np_tx[10:0]};
  wire word_t gig_stat_view = {ms_fault, role_master_in, local_rx_ok_in,
                               remote_rx_ok_in, partner_gig_in, 2'h0,
                               idle_count};
  wire word_t fe_view = {fe_live_in[1], fe_flags[5:4], fe_live_in[0],
                         fe_flags[3:0], 8'h00};
  wire word_t gig2_view = {gig_live_in[1], gig_flags[6:5], gig_live_in[0],
                           gig_flags[4:0], 7'h00};

  word_t read_mux;
  always_comb begin
    read_mux = `ZERO16;
    if (hit(reg_index_in, reg_index_in, ext_page_in)) begin
      unique case (reg_index_in)
        `IDX_ADVERT: read_mux = advert;
        `IDX_PARTNER_BASE: read_mux = partner_base;
        `IDX_EXPANSION: read_mux = exp_view;
        `IDX_NP_TX: read_mux = np_tx_view;
        `IDX_NP_RX: read_mux = partner_np;
        `IDX_GIG_CTRL: read_mux = gig_ctrl;
        `IDX_GIG_STAT: read_mux = gig_stat_view;
        `IDX_MMD_CTRL: read_mux = mmd_ctrl;
        `IDX_MMD_DATA: read_mux = mmd_addr_data;
        `IDX_GIG_EXT1: read_mux = `GIG_EXT1_VALUE;
        `IDX_FE_EXT: read_mux = fe_view;
        `IDX_GIG_EXT2: read_mux = gig2_view;
        default: read_mux = `ZERO16;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rd_data_out <= `ZERO16;
      rd_valid_out <= 1'b0;
      mmd_access_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_in;
      if (rd_in) begin
        rd_data_out <= read_mux;
      end
      // data register accesses reach the device only in a data function, not in mmd_address; increments happen outside
      mmd_access_out <= data_phase && (rd_mmd_data || wr_mmd_data);
    end
  end

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  assign np_tx_word_out = np_tx_view;
  assign advert_out = advert;
  assign test_mode_out = gig_ctrl[`TEST_MODE_HI:`TEST_MODE_LO];
  assign force_role_out = gig_ctrl[`MS_MANUAL_BIT];
  assign forced_master_out = gig_ctrl[`MS_MANUAL_BIT] &&
                             gig_ctrl[`MS_VALUE_BIT];
  assign multi_port_out = gig_ctrl[`PORT_TYPE_BIT];
  assign gig_advert_out = gig_ctrl[`GIG_ADV_HI:`GIG_ADV_LO];
  assign mmd_func_out = mmd_ctrl[`MMD_FUNC_HI:`MMD_FUNC_LO];
  assign mmd_dev_out = mmd_ctrl[`MMD_DEV_HI:`MMD_DEV_LO];
  assign mmd_addr_data_out = mmd_addr_data;
endmodule

// ===== verification/phy_mgmt_regs_monitor.sv
// concurrent checks on the management register bank ports
`timescale 1ns/1ps
`include "phy_mgmt_consts.svh"
module phy_mgmt_regs_monitor (
  input wire logic clk_in, // core clock
  input wire logic resetn_in, // reset, active low
  input wire phy_mgmt_pkg::index_t reg_index_in, // index
  input wire logic [1:0] ext_page_in, // page
  input wire logic wr_in, // write
  input wire logic rd_in, // read
  input wire phy_mgmt_pkg::word_t wr_data_in, // write data
  input wire phy_mgmt_pkg::word_t rd_data_out, // read data
  input wire logic rd_valid_out, // read valid
  input wire logic np_sent_in, // page sent
  input wire phy_mgmt_pkg::word_t np_tx_word_out, // next page
  input wire phy_mgmt_pkg::word_t advert_out, // advertisement
  input wire logic [2:0] test_mode_out, // test mode
  input wire logic force_role_out, // role forced
  input wire logic forced_master_out, // forced master
  input wire logic [1:0] mmd_func_out, // mmd function
  input wire logic mmd_access_out // mmd pulse
);
  import phy_mgmt_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_read_valid_pulse: assert property (rd_in |=> rd_valid_out)
    else $error("read valid missing");
  a_no_stray_valid: assert property (!rd_in |=> !rd_valid_out)
    else $error("read valid without read");
  a_advert_write: assert property (wr_in && reg_index_in == `IDX_ADVERT
    |=> advert_out == ($past(wr_data_in) & `ADVERT_MASK))
    else $error("advertisement write wrong");
  a_test_mode_take: assert property (wr_in && reg_index_in == 5'h09
    && wr_data_in[15:13] <= 3'h4 |=> test_mode_out == $past(wr_data_in[15:13]))
    else $error("test mode not taken");
  a_test_mode_keep: assert property (wr_in && reg_index_in == 5'h09
    && wr_data_in[15:13] > 3'h4 |=> $stable(test_mode_out))
    else $error("reserved test mode taken");
  a_role_forced: assert property (wr_in && reg_index_in == 5'h09
    |=> force_role_out == $past(wr_data_in[12])
    && forced_master_out == ($past(wr_data_in[12])
    && $past(wr_data_in[11])))
    else $error("forced master role wrong");
  a_toggle_flip: assert property (np_sent_in
    |=> np_tx_word_out[11] != $past(np_tx_word_out[11]))
    else $error("toggle did not invert");
  a_redirect_zero: assert property (rd_in && reg_index_in > 5'h0F
    && ext_page_in != 2'h0 |=> rd_data_out == 16'h0000)
    else $error("redirected index read nonzero");
  a_ext_one_fixed: assert property (rd_in && reg_index_in == 5'h0F
    |=> rd_data_out == 16'h3000)
    else $error("extension one value wrong");
  a_mmd_data_pulse: assert property ((wr_in || rd_in)
    && reg_index_in == 5'h0E && mmd_func_out != 2'h0 |=> mmd_access_out)
    else $error("mmd data access pulse missing");
  a_no_mmd_pulse: assert property (!(wr_in || rd_in) |=> !mmd_access_out)
    else $error("mmd pulse without access");
endmodule
bind phy_mgmt_regs phy_mgmt_regs_monitor i_phy_mgmt_regs_monitor (.clk_in,
  .resetn_in, .reg_index_in, .ext_page_in, .wr_in, .rd_in, .wr_data_in,
  .rd_data_out, .rd_valid_out, .np_sent_in, .np_tx_word_out, .advert_out,
  .test_mode_out, .force_role_out, .forced_master_out, .mmd_func_out,
  .mmd_access_out);

// ===== verification/phy_link_partner.sv
// link partner model: received pages and next page transmit events
`timescale 1ns/1ps
module phy_link_partner (
  input wire logic clk_in, // core clock
  output phy_mgmt_pkg::word_t base_out, // base page
  output logic base_load_out, // base page strobe
  output phy_mgmt_pkg::word_t np_out, // next page
  output logic np_load_out, // next page strobe
  output logic np_sent_out // local page went out
);
  import phy_mgmt_pkg::*;
  initial begin
    {base_out, np_out} = '0;
    {base_load_out, np_load_out, np_sent_out} = '0;
  end
  // released page lines show the inverse, never the last word
  task automatic send_page(input logic nxt, input word_t w);
    @(posedge clk_in);
    #1;
    if (nxt) begin
      np_out = w;
      np_load_out = 1'b1;
    end else begin
      base_out = w;
      base_load_out = 1'b1;
    end
    @(posedge clk_in);
    #1;
    {np_load_out, base_load_out} = 2'b00;
    if (nxt) np_out = ~w;
    else base_out = ~w;
  endtask
  task automatic transmit;
    @(posedge clk_in);
    #1;
    np_sent_out = 1'b1;
    @(posedge clk_in);
    #1;
    np_sent_out = 1'b0;
  endtask
endmodule

// ===== verification/phy_mgmt_regs_tb.sv
// self-checking bench for the management register bank
`timescale 1ns/1ps
module phy_mgmt_regs_tb;
  import phy_mgmt_pkg::*;
  logic clk_in, resetn_in, wr_in, rd_in, rd_valid_out, np_sent_in;
  index_t reg_index_in;
  logic [1:0] ext_page_in, partner_gig_in, fe_live_in, gig_live_in;
  logic [1:0] mmd_func_out, gig_advert_out;
  word_t wr_data_in, rd_data_out, partner_base_in, partner_np_in;
  word_t np_tx_word_out, advert_out, mmd_addr_data_out;
  logic partner_base_load_in, partner_np_load_in, partner_an_able_in;
  logic parallel_fault_in, ms_fault_in, role_master_in, idle_error_in;
  logic local_rx_ok_in, remote_rx_ok_in, mmd_access_out;
  logic force_role_out, forced_master_out, multi_port_out;
  logic [5:0] fe_err_in;
  logic [6:0] gig_err_in;
  logic [2:0] test_mode_out, em;
  logic [4:0] mmd_dev_out;
  int n_mismatch, n_compared;
  phy_mgmt_regs i_phy_mgmt_regs (.clk_in, .resetn_in, .reg_index_in,
    .ext_page_in, .wr_in, .rd_in, .wr_data_in, .rd_data_out, .rd_valid_out,
    .partner_base_in, .partner_base_load_in, .partner_np_in,
    .partner_np_load_in, .partner_an_able_in, .parallel_fault_in,
    .np_sent_in, .np_tx_word_out, .advert_out, .test_mode_out,
    .force_role_out, .forced_master_out, .multi_port_out, .gig_advert_out,
    .ms_fault_in, .role_master_in, .local_rx_ok_in, .remote_rx_ok_in,
    .partner_gig_in, .idle_error_in, .fe_live_in, .fe_err_in, .gig_live_in,
    .gig_err_in, .mmd_func_out, .mmd_dev_out, .mmd_addr_data_out,
    .mmd_access_out);
  phy_link_partner i_phy_link_partner (.clk_in, .base_out(partner_base_in),
    .base_load_out(partner_base_load_in), .np_out(partner_np_in),
    .np_load_out(partner_np_load_in), .np_sent_out(np_sent_in));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic cmp(input word_t got, input word_t exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input index_t i, input word_t d);
    tick;
    reg_index_in = i;
    wr_data_in = d;
    wr_in = 1'b1;
    tick;
    wr_in = 1'b0;
  endtask
  task automatic rd(input index_t i, input word_t exp);
    tick;
    reg_index_in = i;
    rd_in = 1'b1;
    tick;
    rd_in = 1'b0;
    cmp(16'(rd_valid_out), 16'h0001);
    cmp(rd_data_out, exp);
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    {resetn_in, wr_in, rd_in, partner_an_able_in, parallel_fault_in} = '0;
    {ms_fault_in, role_master_in, local_rx_ok_in, remote_rx_ok_in} = '0;
    {idle_error_in, reg_index_in, ext_page_in, wr_data_in} = '0;
    {partner_gig_in, fe_live_in, gig_live_in, fe_err_in, gig_err_in} = '0;
    em = 3'h0;
    repeat (6) tick;
    resetn_in = 1'b1;
    rd(5'h04, 16'h01E1);
    rd(5'h07, 16'h2001);
    rd(5'h09, 16'h0300);
    rd(5'h0E, 16'h0000);
    rd(5'h08, 16'h0000);
    rd(5'h05, 16'h0000);
    rd(5'h0F, 16'h3000);
    rd(5'h0B, 16'h0000);
    wr(5'h04, 16'hFFFF);
    rd(5'h04, 16'hADFF);
    cmp(advert_out, 16'hADFF);
    for (int m = 0; m < 8; m++) begin
      wr(5'h09, {m[2:0], 13'h1C00});
      if (m < 5) em = m[2:0];
      cmp(16'({test_mode_out, force_role_out, forced_master_out,
        multi_port_out, gig_advert_out}), 16'({em, 5'h1C}));
      rd(5'h09, {em, 13'h1C00});
    end
    wr(5'h09, 16'h1300);
    cmp(16'({force_role_out, forced_master_out, gig_advert_out}),
      16'h000B);
    partner_an_able_in = 1'b1;
    i_phy_link_partner.send_page(1'b0, 16'hDFE1);
    rd(5'h05, 16'hCFE1);
    parallel_fault_in = 1'b1;
    tick;
    parallel_fault_in = 1'b0;
    i_phy_link_partner.send_page(1'b1, 16'hC805);
    rd(5'h06, 16'h001F);
    rd(5'h06, 16'h000D);
    rd(5'h08, 16'hC805);
    wr(5'h07, 16'hFFFF);
    rd(5'h07, 16'hB7FF);
    for (int k = 0; k < 2; k++) begin
      i_phy_link_partner.transmit;
      cmp(np_tx_word_out, k ? 16'hB7FF : 16'hBFFF);
    end
    {role_master_in, local_rx_ok_in, remote_rx_ok_in} = 3'b111;
    partner_gig_in = 2'b10;
    {ms_fault_in, idle_error_in} = 2'b11;
    repeat (3) tick;
    {ms_fault_in, idle_error_in} = 2'b00;
    rd(5'h0A, 16'hF803);
    rd(5'h0A, 16'h7800);
    idle_error_in = 1'b1;
    repeat (260) tick;
    idle_error_in = 1'b0;
    rd(5'h0A, 16'h78FF);
    {fe_live_in, gig_live_in, fe_err_in, gig_err_in} = '1;
    tick;
    {fe_err_in, gig_err_in} = '0;
    rd(5'h10, 16'hFF00);
    rd(5'h10, 16'h9000);
    rd(5'h11, 16'hFF80);
    rd(5'h11, 16'h9000);
    ext_page_in = 2'h1;
    rd(5'h10, 16'h0000);
    rd(5'h04, 16'hADFF);
    ext_page_in = 2'h0;
    wr(5'h0D, 16'hFFFF);
    rd(5'h0D, 16'hC01F);
    for (int f = 0; f < 4; f++) begin
      wr(5'h0D, {f[1:0], 14'h0005});
      wr(5'h0E, 16'h1234 + f[15:0]);
      cmp(16'(mmd_access_out), 16'(f != 0));
      cmp({mmd_func_out, 9'h000, mmd_dev_out}, {f[1:0], 14'h0005});
      cmp(mmd_addr_data_out, 16'h1234 + f[15:0]);
      rd(5'h0E, 16'h1234 + f[15:0]);
      cmp(16'(mmd_access_out), 16'(f != 0));
    end
    resetn_in = 1'b0;
    repeat (2) tick;
    resetn_in = 1'b1;
    rd(5'h04, 16'h01E1);
    rd(5'h07, 16'h2001);
    rd(5'h0D, 16'h0000);
    give_verdict;
  end
endmodule
